// ### hw/wcc_pkg.sv
package wcc_pkg;

   localparam int ADDR_W = 6;
   localparam int DATA_W = 24;
   localparam int LVL_W = 3;
   localparam int MA_W = 4;
   localparam int NUM_PAIRS = 4;
   localparam int NUM_INPUTS = 24;
   localparam int ON_CYC_W = 17;

   // Register offsets
   localparam logic [5:0] OFS_LEVEL_UPPER = 6'h1E;
   localparam logic [5:0] OFS_PULSE_CFG = 6'h1F;
   localparam logic [5:0] OFS_PULSE_EN = 6'h20;

   // Reset values
   localparam logic [23:0] RST_LEVEL_UPPER = 24'h000000;
   localparam logic [23:0] RST_PULSE_CFG = 24'h000000;
   localparam logic [23:0] RST_PULSE_EN = 24'h000000;

   // Level register fields, one 3-bit code per input pair
   localparam int LVL_12_13_LSB = 0;
   localparam int LVL_14_15_LSB = 3;
   localparam int LVL_16_17_LSB = 6;
   localparam int LVL_18_19_LSB = 9;
   localparam int LVL_USED_W = 12;

   // Pulse configuration fields
   localparam int GRP0_BIT = 0;
   localparam int GRP1_BIT = 1;
   localparam int GRP2_BIT = 2;
   localparam int GRP3_BIT = 3;
   localparam int DUR_LSB = 4;
   localparam int DUR_W = 3;
   localparam int CFG_USED_W = 7;

   // Level codes and currents in mA
   localparam logic [2:0] CODE_NONE = 3'h0;
   localparam logic [2:0] CODE_1MA = 3'h1;
   localparam logic [2:0] CODE_2MA = 3'h2;
   localparam logic [2:0] CODE_5MA = 3'h3;
   localparam logic [2:0] CODE_10MA = 3'h4;
   localparam logic [3:0] MA_0 = 4'h0;
   localparam logic [3:0] MA_1 = 4'h1;
   localparam logic [3:0] MA_2 = 4'h2;
   localparam logic [3:0] MA_5 = 4'h5;
   localparam logic [3:0] MA_10 = 4'hA;
   localparam logic [3:0] MA_15 = 4'hF;

   // Pulse on-time step
   localparam int CLK_PERIOD_NS = 4;
   localparam int PULSE_STEP_US = 64;
   localparam int PULSE_STEP_CYCLES_DFLT = (PULSE_STEP_US * 1000) / CLK_PERIOD_NS;

endpackage

// ### hw/wcc_regs.sv
`timescale 1ns/1ps
`default_nettype none

module wcc_regs #(
   parameter int PULSE_STEP_CYCLES = wcc_pkg::PULSE_STEP_CYCLES_DFLT
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [wcc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [wcc_pkg::DATA_W-1:0] reg_wdata,
   output logic [wcc_pkg::DATA_W-1:0] reg_rdata,
   output logic reg_rd_valid,
   output logic [wcc_pkg::MA_W-1:0] level_pair_12_13_ma,
   output logic [wcc_pkg::MA_W-1:0] level_pair_14_15_ma,
   output logic [wcc_pkg::MA_W-1:0] level_pair_16_17_ma,
   output logic [wcc_pkg::MA_W-1:0] level_pair_18_19_ma,
   output logic [wcc_pkg::MA_W-1:0] pulse_level_grp0_ma,
   output logic [wcc_pkg::MA_W-1:0] pulse_level_grp1_ma,
   output logic [wcc_pkg::MA_W-1:0] pulse_level_grp2_ma,
   output logic [wcc_pkg::MA_W-1:0] pulse_level_grp3_ma,
   output logic [wcc_pkg::ON_CYC_W-1:0] pulse_duration_cycles,
   output logic [wcc_pkg::NUM_INPUTS-1:0] pulse_enable_input_n
);
   import wcc_pkg::*;

   localparam logic [ON_CYC_W-1:0] STEP = ON_CYC_W'(PULSE_STEP_CYCLES);

   function automatic logic [MA_W-1:0] level_decode(input logic [LVL_W-1:0] code);
      case (code)
         CODE_NONE: level_decode = MA_0;
         CODE_1MA: level_decode = MA_1;
         CODE_2MA: level_decode = MA_2;
         CODE_5MA: level_decode = MA_5;
         CODE_10MA: level_decode = MA_10;
         default: level_decode = MA_15;
      endcase
   endfunction

   logic [LVL_USED_W-1:0] level_reg;
   logic [CFG_USED_W-1:0] pulse_cfg_reg;
   logic [NUM_INPUTS-1:0] pulse_en_reg;

   wire hit_level = (reg_addr == OFS_LEVEL_UPPER);
   wire hit_cfg = (reg_addr == OFS_PULSE_CFG);
   wire hit_en = (reg_addr == OFS_PULSE_EN);
   wire wr_level = reg_wr_en && hit_level;
   wire wr_cfg = reg_wr_en && hit_cfg;
   wire wr_en = reg_wr_en && hit_en;

   // Unused upper bits are never stored, so they read back as zero
   wire [LVL_USED_W-1:0] level_next = wr_level ? reg_wdata[LVL_USED_W-1:0] : level_reg;
   wire [CFG_USED_W-1:0] pulse_cfg_next =
      wr_cfg ? reg_wdata[CFG_USED_W-1:0] : pulse_cfg_reg;
   wire [NUM_INPUTS-1:0] pulse_en_next = wr_en ? reg_wdata[NUM_INPUTS-1:0] : pulse_en_reg;

   wire [DATA_W-1:0] rd_mux =
      hit_level ? {{(DATA_W - LVL_USED_W){1'b0}}, level_reg} :
      hit_cfg ? {{(DATA_W - CFG_USED_W){1'b0}}, pulse_cfg_reg} :
      hit_en ? pulse_en_reg :
      {DATA_W{1'b0}};
   wire [DATA_W-1:0] rdata_next = reg_rd_en ? rd_mux : reg_rdata;

   // Pair decode, one instance per pair
   logic [MA_W-1:0] pair_ma [NUM_PAIRS];
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PAIRS; gi++) begin : g_pair
         assign pair_ma[gi] = level_decode(level_reg[gi*LVL_W +: LVL_W]);
      end
   endgenerate

   wire [DUR_W-1:0] dur_code = pulse_cfg_reg[DUR_LSB +: DUR_W];
   wire [ON_CYC_W-1:0] dur_steps = ON_CYC_W'(dur_code) + ON_CYC_W'(1);
   wire [ON_CYC_W-1:0] dur_next = ON_CYC_W'(dur_steps * STEP);
   wire [MA_W-1:0] grp0_next = pulse_cfg_reg[GRP0_BIT] ? MA_15 : MA_10;
   wire [MA_W-1:0] grp1_next = pulse_cfg_reg[GRP1_BIT] ? MA_15 : MA_10;
   wire [MA_W-1:0] grp2_next = pulse_cfg_reg[GRP2_BIT] ? MA_15 : MA_10;
   wire [MA_W-1:0] grp3_next = pulse_cfg_reg[GRP3_BIT] ? MA_15 : MA_10;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         level_reg <= RST_LEVEL_UPPER[LVL_USED_W-1:0];
         pulse_cfg_reg <= RST_PULSE_CFG[CFG_USED_W-1:0];
         pulse_en_reg <= RST_PULSE_EN[NUM_INPUTS-1:0];
      end else begin
         level_reg <= level_next;
         pulse_cfg_reg <= pulse_cfg_next;
         pulse_en_reg <= pulse_en_next;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= {DATA_W{1'b0}};
         reg_rd_valid <= 1'b0;
      end else begin
         reg_rdata <= rdata_next;
         reg_rd_valid <= reg_rd_en;
      end
   end

   // Analogue side sees all settings but the pulse enables one cycle after the register updates
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         level_pair_12_13_ma <= MA_0;
         level_pair_14_15_ma <= MA_0;
         level_pair_16_17_ma <= MA_0;
         level_pair_18_19_ma <= MA_0;
         pulse_level_grp0_ma <= MA_10;
         pulse_level_grp1_ma <= MA_10;
         pulse_level_grp2_ma <= MA_10;
         pulse_level_grp3_ma <= MA_10;
         pulse_duration_cycles <= STEP;
      end else begin
         level_pair_12_13_ma <= pair_ma[0];
         level_pair_14_15_ma <= pair_ma[1];
         level_pair_16_17_ma <= pair_ma[2];
         level_pair_18_19_ma <= pair_ma[3];
         pulse_level_grp0_ma <= grp0_next;
         pulse_level_grp1_ma <= grp1_next;
         pulse_level_grp2_ma <= grp2_next;
         pulse_level_grp3_ma <= grp3_next;
         pulse_duration_cycles <= dur_next;
      end
   end

   assign pulse_enable_input_n = pulse_en_reg;

   level_sat_15_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      (wr_level && reg_wdata[LVL_18_19_LSB +: LVL_W] >= 3'h5) ##1 !wr_level
      |=> level_pair_18_19_ma == MA_15)
      else $error("pair 18/19 code 5-7 did not give 15 mA");

   level_10ma_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      (wr_level && reg_wdata[LVL_16_17_LSB +: LVL_W] == CODE_10MA) ##1 !wr_level
      |=> level_pair_16_17_ma == MA_10)
      else $error("pair 16/17 code 4 did not give 10 mA");

   level_field_place_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_level ##1 (reg_rd_en && hit_level && !reg_wr_en)
      |=> reg_rdata[11:0] == $past(reg_wdata[11:0], 2) && reg_rdata[23:12] == 12'h000)
      else $error("level fields did not read back in place");

   level_zero_idle_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      $past(level_reg[LVL_12_13_LSB +: LVL_W]) == CODE_NONE |-> level_pair_12_13_ma == MA_0)
      else $error("current on pair 12/13 with zero code");

   pulse_time_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_cfg ##1 !wr_cfg
      |=> pulse_duration_cycles ==
         ON_CYC_W'((ON_CYC_W'($past(reg_wdata[6:4], 2)) + ON_CYC_W'(1)) * STEP))
      else $error("pulse duration does not match code");

   grp3_level_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_cfg ##1 !wr_cfg |=> pulse_level_grp3_ma == ($past(reg_wdata[3], 2) ? MA_15 : MA_10))
      else $error("group 3 pulse level wrong");

   grp2_level_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_cfg ##1 !wr_cfg |=> pulse_level_grp2_ma == ($past(reg_wdata[2], 2) ? MA_15 : MA_10))
      else $error("group 2 pulse level wrong");

   grp1_level_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_cfg ##1 !wr_cfg |=> pulse_level_grp1_ma == ($past(reg_wdata[1], 2) ? MA_15 : MA_10))
      else $error("group 1 pulse level wrong");

   grp0_level_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_cfg ##1 !wr_cfg |=> pulse_level_grp0_ma == ($past(reg_wdata[0], 2) ? MA_15 : MA_10))
      else $error("group 0 pulse level wrong");

   enable_write_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_en |=> pulse_enable_input_n == $past(reg_wdata))
      else $error("pulse enables not taken from write");

   enable_hold_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      !wr_en |=> $stable(pulse_enable_input_n))
      else $error("pulse enables changed without a write");

   enable_readback_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      reg_rd_en && reg_addr == OFS_PULSE_EN
      |=> reg_rd_valid && reg_rdata == $past(pulse_enable_input_n))
      else $error("pulse enable readback wrong");

   cfg_reserved_zero_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      reg_rd_en && reg_addr == OFS_PULSE_CFG
      |=> reg_rd_valid && reg_rdata[DATA_W-1:CFG_USED_W] == {(DATA_W - CFG_USED_W){1'b0}})
      else $error("reserved config bits read nonzero");

   rd_valid_set_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      reg_rd_en |=> reg_rd_valid)
      else $error("read strobe gave no valid");

   rd_valid_once_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      !reg_rd_en |=> !reg_rd_valid)
      else $error("read valid without a read");

   rdata_hold_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      !reg_rd_en |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   unmapped_read_zero_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      reg_rd_en && !hit_level && !hit_cfg && !hit_en |=> reg_rdata == {DATA_W{1'b0}})
      else $error("unmapped read gave nonzero data");

   level_top_zero_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      reg_rd_en && hit_level |=> reg_rdata[DATA_W-1:LVL_USED_W] == {(DATA_W - LVL_USED_W){1'b0}})
      else $error("unused level bits read nonzero");

   level_readback_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      reg_rd_en && hit_level |=> reg_rdata[LVL_USED_W-1:0] == $past(level_reg))
      else $error("level register readback wrong");

   cfg_readback_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      reg_rd_en && hit_cfg |=> reg_rdata[CFG_USED_W-1:0] == $past(pulse_cfg_reg))
      else $error("pulse config readback wrong");

   level_write_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_level |=> level_reg == $past(reg_wdata[LVL_USED_W-1:0]))
      else $error("level register not taken from write");

   level_hold_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      !wr_level |=> $stable(level_reg))
      else $error("level register changed without a write");

   cfg_write_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      wr_cfg |=> pulse_cfg_reg == $past(reg_wdata[CFG_USED_W-1:0]))
      else $error("pulse config not taken from write");

   cfg_hold_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      !wr_cfg |=> $stable(pulse_cfg_reg))
      else $error("pulse config changed without a write");

   pair12_1ma_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      $past(level_reg[LVL_12_13_LSB +: LVL_W]) == CODE_1MA |-> level_pair_12_13_ma == MA_1)
      else $error("pair 12/13 code 1 did not give 1 mA");

   pair14_2ma_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      $past(level_reg[LVL_14_15_LSB +: LVL_W]) == CODE_2MA |-> level_pair_14_15_ma == MA_2)
      else $error("pair 14/15 code 2 did not give 2 mA");

   pair14_5ma_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      $past(level_reg[LVL_14_15_LSB +: LVL_W]) == CODE_5MA |-> level_pair_14_15_ma == MA_5)
      else $error("pair 14/15 code 3 did not give 5 mA");

   pair12_sat_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      $past(level_reg[LVL_12_13_LSB +: LVL_W]) >= 3'h5 |-> level_pair_12_13_ma == MA_15)
      else $error("pair 12/13 code 5-7 did not give 15 mA");

   pair14_zero_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      $past(level_reg[LVL_14_15_LSB +: LVL_W]) == CODE_NONE |-> level_pair_14_15_ma == MA_0)
      else $error("current on pair 14/15 with zero code");

   pair16_zero_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      $past(level_reg[LVL_16_17_LSB +: LVL_W]) == CODE_NONE |-> level_pair_16_17_ma == MA_0)
      else $error("current on pair 16/17 with zero code");

   pair18_zero_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      $past(level_reg[LVL_18_19_LSB +: LVL_W]) == CODE_NONE |-> level_pair_18_19_ma == MA_0)
      else $error("current on pair 18/19 with zero code");

   dur_bound_a: assert property (
      @(posedge sys_clk) disable iff (!nrst)
      pulse_duration_cycles >= STEP
      && pulse_duration_cycles <= ON_CYC_W'(8 * PULSE_STEP_CYCLES))
      else $error("pulse duration outside one to eight steps");

endmodule

`default_nettype wire

// ### verif/wcc_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host side of the register port, one access per task call
module wcc_host (
   input wire logic sys_clk,
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [wcc_pkg::ADDR_W-1:0] reg_addr,
   output logic [wcc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic [wcc_pkg::DATA_W-1:0] reg_rdata,
   input wire logic reg_rd_valid
);
   import wcc_pkg::*;
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 6'h3F;
      reg_wdata = 24'h000000;
   end
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(posedge sys_clk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr_en <= 1'b0;
      // Idle data flips so a stale word never passes for a fresh one
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic v);
      @(posedge sys_clk);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd_en <= 1'b0;
      #1;
      v = reg_rd_valid;
      d = reg_rdata;
   endtask
endmodule

`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import wcc_pkg::*;
   // Short pulse step keeps duration checks cheap
   localparam int STEP = 4;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic reg_wr_en, reg_rd_en, reg_rd_valid;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata;
   logic [MA_W-1:0] l0, l1, l2, l3, g0, g1, g2, g3;
   logic [ON_CYC_W-1:0] dur;
   logic [NUM_INPUTS-1:0] en;
   int bad_count = 0;
   int checked = 0;
   always #2 sys_clk = ~sys_clk;
   wcc_regs #(.PULSE_STEP_CYCLES(STEP)) dut (.sys_clk(sys_clk), .nrst(nrst),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
      .level_pair_12_13_ma(l0), .level_pair_14_15_ma(l1), .level_pair_16_17_ma(l2),
      .level_pair_18_19_ma(l3), .pulse_level_grp0_ma(g0), .pulse_level_grp1_ma(g1),
      .pulse_level_grp2_ma(g2), .pulse_level_grp3_ma(g3),
      .pulse_duration_cycles(dur), .pulse_enable_input_n(en));
   wcc_host host (.sys_clk(sys_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid));
   function automatic logic [3:0] ma_of(input logic [2:0] c);
      case (c)
         3'h0: return 4'h0;
         3'h1: return 4'h1;
         3'h2: return 4'h2;
         3'h3: return 4'h5;
         3'h4: return 4'hA;
         default: return 4'hF;
      endcase
   endfunction
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_ma(input logic [3:0] got, input logic [3:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t current %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp);
      logic [23:0] d;
      logic v;
      host.rd(a, d, v);
      chk({23'h0, v}, 24'h000001);
      chk(d, exp);
   endtask
   task automatic settle();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic t_reset();
      rd_chk(OFS_LEVEL_UPPER, 24'h000000);
      rd_chk(OFS_PULSE_CFG, 24'h000000);
      rd_chk(OFS_PULSE_EN, 24'h000000);
      chk({8'h00, l3, l2, l1, l0}, 24'h000000);
      chk({8'h00, g3, g2, g1, g0}, 24'h00AAAA);
      chk(24'(dur), 24'(STEP));
      chk(en, 24'h000000);
   endtask
   task automatic t_level();
      logic [2:0] c;
      logic [23:0] v;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         v = {12'hFFF, 3'(c + 3'h3), 3'(c + 3'h2), 3'(c + 3'h1), c};
         host.wr(OFS_LEVEL_UPPER, v);
         settle();
         chk_ma(l0, ma_of(v[2:0]));
         chk_ma(l1, ma_of(v[5:3]));
         chk_ma(l2, ma_of(v[8:6]));
         chk_ma(l3, ma_of(v[11:9]));
         rd_chk(OFS_LEVEL_UPPER, {12'h000, v[11:0]});
      end
   endtask
   task automatic t_pulse();
      logic [2:0] d;
      logic [3:0] g;
      for (int i = 0; i < 8; i++) begin
         d = 3'(i);
         // Each group bit is seen set alone and clear alone
         g = (4'h1 << d[1:0]) ^ {4{d[2]}};
         host.wr(OFS_PULSE_CFG, {17'h1FFFF, d, g});
         settle();
         chk(24'(dur), 24'((i + 1) * STEP));
         chk_ma(g3, g[3] ? 4'hF : 4'hA);
         chk_ma(g2, g[2] ? 4'hF : 4'hA);
         chk_ma(g1, g[1] ? 4'hF : 4'hA);
         chk_ma(g0, g[0] ? 4'hF : 4'hA);
         rd_chk(OFS_PULSE_CFG, {17'h00000, d, g});
      end
   endtask
   task automatic t_enable();
      logic [23:0] v;
      for (int n = 0; n < 25; n++) begin
         v = (n == 24) ? 24'hFFFFFF : 24'h000001 << n;
         host.wr(OFS_PULSE_EN, v);
         #1;
         chk(en, v);
         rd_chk(OFS_PULSE_EN, v);
      end
   endtask
   task automatic t_unmapped();
      host.wr(6'h21, 24'h123456);
      rd_chk(6'h21, 24'h000000);
      rd_chk(OFS_PULSE_EN, 24'hFFFFFF);
      rd_chk(OFS_PULSE_CFG, 24'h000077);
   endtask
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      nrst <= 1'b1;
      t_reset();
      t_level();
      t_pulse();
      t_enable();
      t_unmapped();
      // Mid-run reset must clear every field again
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      t_reset();
      end_sim();
   end
   initial begin
      #20000;
      bad_count++;
      end_sim();
   end
endmodule

`default_nettype wire
